/* rtl/cdte_defines.svh */
// Purpose: register offsets, field positions, reset values and timing counts for card detect evaluation
// Assumes: 8-bit register port with 7-bit addresses
// Notes:   definitions only
`ifndef CDTE_DEFINES_SVH
`define CDTE_DEFINES_SVH

// register offsets
`define CDTE_OFS_OPTIONS      7'h3a
`define CDTE_OFS_Q_LOWER      7'h3f
`define CDTE_OFS_Q_UPPER      7'h40
`define CDTE_OFS_I_LOWER      7'h41
`define CDTE_OFS_I_RESULT     7'h42
`define CDTE_OFS_Q_RESULT     7'h43

// field positions
`define CDTE_TH_MSB           5
`define CDTE_IMAX_HI_BIT      7
`define CDTE_IMAX_LO_BIT      6
`define CDTE_SUPPRESS_BIT     6
`define CDTE_OPT_TX_HIGH_BIT  3
`define CDTE_OPT_FILTER_BIT   2
`define CDTE_OPT_Q_UNST_BIT   1
`define CDTE_OPT_I_UNST_BIT   0

// reset values
`define CDTE_RST_BYTE         8'h00
`define CDTE_RST_VAL6         6'h00

// timing: longest total filtered sampling time, in ps, rounded down to cycles
`define CDTE_FILT_SAMPLE_PS   4720000
`define CDTE_CLK_PERIOD_PS    50000
`define CDTE_FILT_SAMPLE_CYC  (`CDTE_FILT_SAMPLE_PS / `CDTE_CLK_PERIOD_PS)

`endif

/* rtl/cdte_pkg.sv */
// Purpose: types shared by the card detect evaluation block
// Assumes: nothing beyond the defines header
// Notes:   one-hot measurement sequencer states
package cdte_pkg;
  typedef enum logic [2:0] {
    CDTE_IDLE   = 3'b001,  // waiting for a detection run
    CDTE_SAMPLE = 3'b010,  // converters sampling
    CDTE_EVAL   = 3'b100   // single compare slot
  } cdte_state_t;
endpackage

/* rtl/cdte_compare.sv */
// Purpose: threshold comparison of one measured I/Q pair
// Assumes: unsigned 6-bit values
// Notes:   purely combinational, evaluated every cycle, verdict taken in the eval state
`timescale 1ns/10ps
module cdte_compare #(
  parameter int W = 6
) (
  // measured values
  input  wire logic [W-1:0] i_val,
  input  wire logic [W-1:0] q_val,
  // thresholds
  input  wire logic [W-1:0] i_upper,
  input  wire logic [W-1:0] i_lower,
  input  wire logic [W-1:0] q_upper,
  // verdict
  output logic              hit
);
  // unsigned compares on all three bounds
  always_comb begin
    hit = (i_val > i_upper) ||
          (q_val > q_upper) ||
          (i_val < i_lower);
  end
endmodule

/* rtl/cdte_top.sv */
// Purpose: register file and evaluation logic for low power card detection
// Assumes: analog front end reports raw or filtered 6-bit I and Q with a done strobe
// Notes:   8-bit register port with write and read strobes, read data registered
`timescale 1ns/10ps
`include "cdte_defines.svh"

module cdte_top #(
  parameter int         W            = 6,     // channel width
  parameter bit         LATER_REV    = 1'b1,  // options register present
  parameter int unsigned SAMPLE_CYC  = `CDTE_FILT_SAMPLE_CYC  // filtered sampling limit
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // register port
  input  wire logic [6:0]   reg_addr,
  input  wire logic [7:0]   reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic      [7:0]   reg_rdata,
  // analog front end
  input  wire logic         detect_start,   // run begins
  input  wire logic         detect_done,    // run ends, values valid
  input  wire logic [W-1:0] i_raw,
  input  wire logic [W-1:0] q_raw,
  input  wire logic [W-1:0] i_filt,
  input  wire logic [W-1:0] q_filt,
  input  wire logic         i_changed,      // i converter moved during run
  input  wire logic         q_changed,      // q converter moved during run
  output logic              full_tx_drive_during_detect,
  output logic              detect_noise_filter_en,
  output logic              sample_limit,   // filtered sampling time used up
  // interrupt flag interface
  input  wire logic         irq_flag_clr,
  output logic              card_detect_irq_flag
);

  // register storage
  logic [7:0]             q_lower_reg, q_lower_next;
  logic [7:0]             q_upper_reg, q_upper_next;
  logic [7:0]             i_lower_reg, i_lower_next;
  logic [W-1:0]           i_res_reg, i_res_next;
  logic [W-1:0]           q_res_reg, q_res_next;
  logic                   supp_reg, supp_next;
  logic [1:0]             opt_ctl_reg, opt_ctl_next;   // tx high, filter
  logic [1:0]             unst_reg, unst_next;          // q, i
  logic                   flag_reg, flag_next;
  logic [7:0]             rdata_reg, rdata_next;
  // sequencer
  cdte_pkg::cdte_state_t  st_reg, st_next;
  logic [15:0]            cnt_reg, cnt_next;
  // combinational
  logic [W-1:0]           i_upper;
  logic [W-1:0]           i_use, q_use;
  logic                   hit;
  logic                   opt_vis;

  // i upper threshold assembled from three registers
  assign i_upper = {q_lower_reg[`CDTE_IMAX_HI_BIT:`CDTE_IMAX_LO_BIT],
                    q_upper_reg[`CDTE_IMAX_HI_BIT:`CDTE_IMAX_LO_BIT],
                    i_lower_reg[`CDTE_IMAX_HI_BIT:`CDTE_IMAX_LO_BIT]};

  // filtered or raw values feed the decision
  assign i_use = opt_ctl_reg[0] ? i_filt : i_raw;
  assign q_use = opt_ctl_reg[0] ? q_filt : q_raw;
  assign opt_vis = LATER_REV;

  cdte_compare #(.W(W)) u_cmp (
    .i_val   (i_use),
    .q_val   (q_use),
    .i_upper (i_upper),
    .i_lower (i_lower_reg[`CDTE_TH_MSB:0]),
    .q_upper (q_upper_reg[`CDTE_TH_MSB:0]),
    .hit     (hit)
  );

  // sequencer: count sampling time, compare once at run end
  always_comb begin
    st_next  = st_reg;
    cnt_next = cnt_reg;
    unique case (st_reg)
      cdte_pkg::CDTE_IDLE: begin
        cnt_next = 16'h0000;
        if (detect_start) begin
          st_next = cdte_pkg::CDTE_SAMPLE;
        end
      end
      cdte_pkg::CDTE_SAMPLE: begin
        if (detect_done) begin
          st_next = cdte_pkg::CDTE_EVAL;
        end else if (cnt_reg != 16'hffff) begin
          cnt_next = cnt_reg + 16'h0001;
        end
      end
      cdte_pkg::CDTE_EVAL: begin
        st_next = cdte_pkg::CDTE_IDLE;  // one compare per run
      end
      default: begin
        st_next = cdte_pkg::CDTE_IDLE;
      end
    endcase
  end

  // tell the front end when the filtered window is used up
  assign sample_limit = (st_reg == cdte_pkg::CDTE_SAMPLE) && opt_ctl_reg[0] &&
                        (32'(cnt_reg) >= SAMPLE_CYC - 1);

  // register writes, result capture, flag
  always_comb begin
    q_lower_next = q_lower_reg;
    q_upper_next = q_upper_reg;
    i_lower_next = i_lower_reg;
    i_res_next   = i_res_reg;
    q_res_next   = q_res_reg;
    supp_next    = supp_reg;
    opt_ctl_next = opt_ctl_reg;
    unst_next    = unst_reg;
    flag_next    = flag_reg;
    if (reg_wr) begin
      unique case (reg_addr)
        `CDTE_OFS_Q_LOWER: q_lower_next = reg_wdata;
        `CDTE_OFS_Q_UPPER: q_upper_next = reg_wdata;
        `CDTE_OFS_I_LOWER: i_lower_next = reg_wdata;
        `CDTE_OFS_Q_RESULT: supp_next = reg_wdata[`CDTE_SUPPRESS_BIT];
        `CDTE_OFS_OPTIONS: begin
          if (opt_vis) begin  // earlier revision ignores the write
            opt_ctl_next = {reg_wdata[`CDTE_OPT_TX_HIGH_BIT], reg_wdata[`CDTE_OPT_FILTER_BIT]};
          end
        end
        default: begin
        end
      endcase
    end
    // a new run lifts suppression
    if (st_reg == cdte_pkg::CDTE_IDLE && detect_start) begin
      supp_next = 1'b0;
    end
    // clear first so that a same-cycle event wins
    if (irq_flag_clr) begin
      flag_next = 1'b0;
    end
    if (st_reg == cdte_pkg::CDTE_EVAL) begin
      i_res_next = i_use;
      q_res_next = q_use;
      unst_next  = {q_changed, i_changed};
      if (hit && !supp_reg) begin
        flag_next = 1'b1;
      end
    end
  end

  // read mux, registered data
  always_comb begin
    rdata_next = rdata_reg;
    if (reg_rd) begin
      unique case (reg_addr)
        `CDTE_OFS_Q_LOWER:  rdata_next = q_lower_reg;
        `CDTE_OFS_Q_UPPER:  rdata_next = q_upper_reg;
        `CDTE_OFS_I_LOWER:  rdata_next = i_lower_reg;
        `CDTE_OFS_I_RESULT: rdata_next = {2'b00, i_res_reg};
        `CDTE_OFS_Q_RESULT: rdata_next = {1'b0, supp_reg, q_res_reg};
        `CDTE_OFS_OPTIONS:  rdata_next = opt_vis ?
                              {4'h0, opt_ctl_reg, unst_reg} : 8'h00;
        default:            rdata_next = 8'h00;
      endcase
    end
  end

  // state registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q_lower_reg <= `CDTE_RST_BYTE;
      q_upper_reg <= `CDTE_RST_BYTE;
      i_lower_reg <= `CDTE_RST_BYTE;
      i_res_reg   <= `CDTE_RST_VAL6;
      q_res_reg   <= `CDTE_RST_VAL6;
      supp_reg    <= 1'b0;
      opt_ctl_reg <= 2'b00;
      unst_reg    <= 2'b00;
      flag_reg    <= 1'b0;
      rdata_reg   <= `CDTE_RST_BYTE;
      st_reg      <= cdte_pkg::CDTE_IDLE;
      cnt_reg     <= 16'h0000;
    end else begin
      q_lower_reg <= q_lower_next;
      q_upper_reg <= q_upper_next;
      i_lower_reg <= i_lower_next;
      i_res_reg   <= i_res_next;
      q_res_reg   <= q_res_next;
      supp_reg    <= supp_next;
      opt_ctl_reg <= opt_ctl_next;
      unst_reg    <= unst_next;
      flag_reg    <= flag_next;
      rdata_reg   <= rdata_next;
      st_reg      <= st_next;
      cnt_reg     <= cnt_next;
    end
  end

  // outputs
  assign reg_rdata                   = rdata_reg;
  assign card_detect_irq_flag        = flag_reg;
  assign full_tx_drive_during_detect = opt_ctl_reg[1];
  assign detect_noise_filter_en      = opt_ctl_reg[0];

  // checks
  a_flag_on_hit: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg == cdte_pkg::CDTE_EVAL && hit && !supp_reg) |=> card_detect_irq_flag)
    else $error("hit did not raise flag");
  a_suppress_blocks: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg == cdte_pkg::CDTE_EVAL && supp_reg && !card_detect_irq_flag) |=> !card_detect_irq_flag)
    else $error("flag raised while suppressed");
  a_imax_assembly: assert property (@(posedge clk) disable iff (!rst_n)
    i_upper[3:2] == q_upper_reg[7:6] && i_upper[1:0] == i_lower_reg[7:6] && i_upper[5:4] == q_lower_reg[7:6])
    else $error("i upper assembly wrong");
  a_q_exceed: assert property (@(posedge clk) disable iff (!rst_n)
    (q_use > q_upper_reg[5:0]) |-> hit)
    else $error("q exceed missed");
  a_i_below: assert property (@(posedge clk) disable iff (!rst_n)
    (i_use < i_lower_reg[5:0]) |-> hit)
    else $error("i below missed");
  a_result_capture: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg == cdte_pkg::CDTE_EVAL) |=> (i_res_reg == $past(i_use)) && (q_res_reg == $past(q_use)))
    else $error("result not captured");
  a_tx_drive: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == `CDTE_OFS_OPTIONS && LATER_REV) |=>
      full_tx_drive_during_detect == $past(reg_wdata[3]))
    else $error("tx drive not updated");
  a_eval_once: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg == cdte_pkg::CDTE_EVAL) |=> (st_reg == cdte_pkg::CDTE_IDLE))
    else $error("evaluation repeated");
  a_supp_lift: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg == cdte_pkg::CDTE_IDLE && detect_start && !reg_wr) |=> !supp_reg)
    else $error("suppress not lifted");
endmodule

/* test/cdte_afe_model.sv */
// Purpose: behavioural stand-in for the I and Q measurement converters
// Assumes: the evaluator samples readings in the cycle after the done strobe
// Notes:   readings are zero until the first eval cycle and show the inverse of the last readings after each one
`timescale 1ns/10ps
module cdte_afe_model #(
  parameter int W = 6  // channel width
) (
  // clock
  input  wire logic         clk,
  // run strobes
  output logic              detect_start,
  output logic              detect_done,
  // converter readings
  output logic [W-1:0]      i_raw,
  output logic [W-1:0]      q_raw,
  output logic [W-1:0]      i_filt,
  output logic [W-1:0]      q_filt,
  output logic              i_changed,
  output logic              q_changed
);
  // quiet strobes and defined readings at time zero
  initial begin
    {detect_start, detect_done} = 2'b00;
    {i_raw, q_raw, i_filt, q_filt, i_changed, q_changed} = '0;
  end

  // one-cycle start pulse
  task automatic begin_run();
    @(posedge clk) detect_start <= 1'b1;
    @(posedge clk) detect_start <= 1'b0;
  endtask

  // done pulse, then readings valid for the eval cycle only
  task automatic end_run(input logic [W-1:0] ir, qr, fi, fq, input logic ic, qc);
    @(posedge clk) detect_done <= 1'b1;
    @(posedge clk) begin
      detect_done <= 1'b0;
      {i_raw, q_raw, i_filt, q_filt, i_changed, q_changed} <= {ir, qr, fi, fq, ic, qc};
    end
    // inverse afterwards, so a late sample cannot match by luck
    @(posedge clk) {i_raw, q_raw, i_filt, q_filt, i_changed, q_changed} <= ~{ir, qr, fi, fq, ic, qc};
  endtask
endmodule

/* test/cdte_top_test.sv */
// Purpose: register and detection sequences for the card detect evaluator
// Assumes: short sampling limit of 4 cycles
// Notes:   a second instance stands for the earlier silicon revision
`timescale 1ns/10ps
module cdte_top_test;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;        // held low for 5 cycles
  logic [6:0] reg_addr = 7'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       irq_flag_clr = 1'b0;
  logic [7:0] reg_rdata, rdata_old;  // later and earlier revision
  logic       detect_start, detect_done, i_changed, q_changed;
  logic       full_tx, filt_en, sample_limit, irq_flag;
  logic [5:0] i_raw, q_raw, i_filt, q_filt;
  int         err_count = 0;
  int         checks_done = 0;
  logic [6:0] amap [7] = '{7'h3a, 7'h3f, 7'h40, 7'h41, 7'h42, 7'h43, 7'h10};

  always #25 clk = ~clk;

  // design under test, later revision, short sampling limit
  cdte_top #(.SAMPLE_CYC(4)) cdte_top_inst (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .detect_start(detect_start), .detect_done(detect_done), .i_raw(i_raw), .q_raw(q_raw),
    .i_filt(i_filt), .q_filt(q_filt), .i_changed(i_changed), .q_changed(q_changed),
    .full_tx_drive_during_detect(full_tx), .detect_noise_filter_en(filt_en),
    .sample_limit(sample_limit), .irq_flag_clr(irq_flag_clr), .card_detect_irq_flag(irq_flag));
  // earlier revision: only its options read-back is watched
  cdte_top #(.LATER_REV(1'b0)) cdte_top_rev0_inst (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata_old),
    .detect_start(detect_start), .detect_done(detect_done), .i_raw(i_raw), .q_raw(q_raw),
    .i_filt(i_filt), .q_filt(q_filt), .i_changed(i_changed), .q_changed(q_changed),
    .full_tx_drive_during_detect(), .detect_noise_filter_en(), .sample_limit(),
    .irq_flag_clr(irq_flag_clr), .card_detect_irq_flag());
  // converter stand-in drives every analog input
  cdte_afe_model cdte_afe_model_inst (.clk(clk), .detect_start(detect_start), .detect_done(detect_done),
    .i_raw(i_raw), .q_raw(q_raw), .i_filt(i_filt), .q_filt(q_filt), .i_changed(i_changed),
    .q_changed(q_changed));

  // four-state compare, counted
  task automatic chk(input logic [7:0] got, exp, input string m);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  // verdict and end of run
  task automatic close_out();
    if (err_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read strobe; data is registered, so look one cycle later
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    @(posedge clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, e, "register read");
  endtask

  // clear flag, run a detection, optionally set suppress mid-run
  task automatic run(input logic [5:0] ir, qr, fi, fq, input logic ic, qc, fl, lim, supp);
    @(posedge clk) irq_flag_clr <= 1'b1;
    @(posedge clk) irq_flag_clr <= 1'b0;
    @(negedge clk) chk(8'(irq_flag), 8'h00, "flag clear");
    cdte_afe_model_inst.begin_run();
    if (supp) wr(7'h43, 8'h40);
    repeat (5) @(posedge clk);
    @(negedge clk) chk(8'(sample_limit), 8'(lim), "sample limit");
    cdte_afe_model_inst.end_run(ir, qr, fi, fq, ic, qc);
    @(negedge clk) chk(8'(irq_flag), 8'(fl), "detect flag");
    // result bytes only checked for unfiltered runs
    if (!lim) begin
      rd(7'h42, {2'b00, ir});
      rd(7'h43, {1'b0, supp, qr});
    end
  endtask

  // hang guard, far beyond the expected run length
  initial begin
    repeat (4000) @(posedge clk);
    err_count++;
    close_out();
  end

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    foreach (amap[k]) rd(amap[k], 8'h00);
    // upper I bound 6'b10_01_10 = 38, upper Q 48, lower I 8
    wr(7'h3f, 8'h85);
    wr(7'h40, 8'h70);
    wr(7'h41, 8'h88);
    rd(7'h40, 8'h70);
    rd(7'h41, 8'h88);
    run(6'd38, 6'd48, 6'h3f, 6'h3f, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    run(6'd39, 6'd20, 6'h00, 6'h00, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    run(6'd20, 6'd49, 6'h00, 6'h00, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    run(6'd7, 6'd20, 6'h00, 6'h00, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    run(6'd8, 6'd48, 6'h00, 6'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    // result byte is read-only, only the suppress bit is writable
    wr(7'h42, 8'hff);
    rd(7'h42, 8'h08);
    wr(7'h43, 8'hff);
    rd(7'h43, 8'h70);
    // the next start clears suppress; a mid-run suppress blocks the flag
    run(6'd39, 6'd20, 6'h00, 6'h00, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    run(6'd39, 6'd20, 6'h00, 6'h00, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    // options: upper nibble reserved, unstable bits read-only
    wr(7'h3a, 8'hff);
    rd(7'h3a, 8'h0d);
    chk(rdata_old, 8'h00, "old revision options");
    chk(8'(full_tx), 8'h01, "full tx drive");
    chk(8'(filt_en), 8'h01, "filter enable");
    // filtered decision ignores the raw values
    run(6'd38, 6'd48, 6'd39, 6'd20, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
    rd(7'h3a, 8'h0e);
    run(6'd39, 6'd49, 6'd38, 6'd48, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
    rd(7'h3a, 8'h0f);
    wr(7'h3a, 8'h00);
    rd(7'h3a, 8'h03);
    chk(8'(full_tx), 8'h00, "reduced tx drive");
    close_out();
  end
endmodule
